// [hw/stm_defines.svh]
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH

// word geometry
`define STM_WORD_W      12
`define STM_WORD_BITS   13
`define STM_INST_W      23
`define STM_OUT_W       24

// defaults of the array
`define STM_NUM_MOD     4
`define STM_BIT_DIV     8

// latch bit positions, one subinstruction each
`define STM_SI_LDD      0
`define STM_SI_LDA      1
`define STM_SI_ADD      2
`define STM_SI_LDB      3
`define STM_SI_OB       4
`define STM_SI_SHR      5
`define STM_SI_LDT      6
`define STM_SI_LDR      7
`define STM_SI_CMP_BASE 8
`define STM_SI_USE_REF  14
`define STM_SI_USE_T    15
`define STM_SI_CLRW     16

`endif

// [hw/stm_pkg.sv]
`include "stm_defines.svh"

package stm_pkg;
  typedef logic [`STM_WORD_W-1:0] stm_word_type;
  typedef logic [`STM_INST_W-1:0] stm_inst_type;
  typedef logic [`STM_OUT_W-1:0]  stm_out_type;
endpackage

// [hw/stm_complementer.sv]
`timescale 1ns/1ps
`default_nettype none

module stm_complementer (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic tick,
  input  wire logic first,
  input  wire logic en,
  input  wire logic din,
  output logic      dout
);
  logic seen_r;

  // copy up to the first one, invert after it
  always_comb
  begin
    dout = din ^ (en & ~first & seen_r);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      seen_r <= 1'b0;
    else if (tick)
      seen_r <= first ? din : (seen_r | din);
  end
endmodule

`default_nettype wire

// [hw/stm_serial_adder.sv]
`timescale 1ns/1ps
`default_nettype none

module stm_serial_adder (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic tick,
  input  wire logic first,
  input  wire logic last,
  input  wire logic a,
  input  wire logic b,
  output logic      sum,
  output logic      ext_r,
  output logic      ovf_r
);
  logic c_r;
  logic cin;
  logic cout;

  always_comb
  begin
    cin  = first ? 1'b0 : c_r;
    sum  = a ^ b ^ cin;
    cout = (a & b) | (a & cin) | (b & cin);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      c_r <= 1'b0;
    else if (tick)
      c_r <= cout;
  end

  // sign stage: true 13th bit kept so halving repairs the word
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ovf_r <= 1'b0;
      ext_r <= 1'b0;
    end
    else if (tick && last)
    begin
      ovf_r <= cin ^ cout;
      ext_r <= a ^ b ^ cout;
    end
  end
endmodule

`default_nettype wire

// [hw/stm_array.sv]
`timescale 1ns/1ps
`default_nettype none
`include "stm_defines.svh"

// What this block does
// (RL1) all data words twelve bits wide
// (RL2) samples enter serially, real and imaginary together
// (RL3) modules chained so samples flow down
// (RL4) window size equals number of loads, capped at two per module
// (RL5) all results presented together, bit serial
// (RL6) output shifts real, imaginary moves into real
// (RL7) external buffer: 24-bit shifter plus holding register
// (RL8) results leave upward in natural order
// (RL9) module gets samples i and i+N/2
// (RL10) one bit per bit time, lockstep
// (RL11) each module forms sum and difference
// (RL12) k iterations for 2^k points
// (RL13) two coefficient registers per module, real then imaginary
// (RL14) coefficients feed premultiply and reference words
// (RL15) control unit reads, decodes, broadcasts program
// (RL16) control unit drives the execution timing; here div_r and bit_r set it and control supplies only inst_shift
// (RL17) eighteen word registers, six enabled complementers
// (RL18) four serial adders catch and correct overflow
// (RL19) automatic scaling keeps full range
// (RL20) load may overlap last word; output may defer
// (RL21) module serves two samples or one filter
// (RL22) instruction shifted in, latched at word end
// (RL23) one latch bit per subinstruction
// (RL24) any overflow halves data in every module
// (RL25) one word per thirteen bit times, two words per 24-bit output word
// (RL26) serial arithmetic least significant bit first
// (RL27) complementers negate when individually enabled
module stm_array
  import stm_pkg::*;
#(
  parameter int NUM_MOD = `STM_NUM_MOD,
  parameter int BIT_DIV = `STM_BIT_DIV
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic                     inst_bit,
  input  wire logic                     inst_shift,
  input  wire logic                     din_re,
  input  wire logic                     din_im,
  input  wire logic                     coef_in,
  input  wire logic                     coef_load,
  input  wire logic                     ovf_notify,
  input  wire logic                     out_ready,
  output stm_out_type                   out_data,
  output logic                          out_valid,
  output logic [2*NUM_MOD-1:0]          res_re_bits,
  output logic [2*NUM_MOD-1:0]          res_im_bits,
  output logic                          word_end,
  output logic                          overflow_flag,
  output logic                          result_ready,
  output logic                          stall,
  output logic [$clog2(2*NUM_MOD):0]    window_count,
  output logic [$clog2(2*NUM_MOD)-1:0]  iter_count
);
  // (RL1) twelve-bit data words
  localparam int W     = `STM_WORD_W;
  localparam int M     = NUM_MOD;
  localparam int LOG2N = $clog2(2 * NUM_MOD);
  localparam int DW    = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;
  localparam int CB    = `STM_SI_CMP_BASE;

  if (NUM_MOD < 2 || (NUM_MOD & (NUM_MOD - 1)) != 0)
    $error("NUM_MOD must be a power of two of at least 2");
  if (BIT_DIV < 1)
    $error("BIT_DIV must be at least 1");

  function automatic int stm_rev(input int v);
    int r;
    r = 0;
    for (int i = 0; i < LOG2N; i++)
      r = r | (((v >> i) & 1) << (LOG2N - 1 - i));
    return r;
  endfunction

  // word timing
  logic [DW-1:0]    div_r;
  logic [3:0]       bit_r;
  logic             tick;
  logic             data_tick;
  logic             gap_tick;
  logic             first;
  logic             last;
  // instruction path
  stm_inst_type     inst_sr_r;
  stm_inst_type     latch_r;
  // datapath storage
  stm_word_type     d_r [M][4];
  stm_word_type     a_r [M][4];
  stm_word_type     b_r [M][4];
  stm_word_type     t_r [M][4];
  stm_word_type     reference_register_r [M][2];
  stm_word_type     coef_r [2*M];
  logic [3:0]       dchain [M];
  logic [3:0]       shuf   [M];
  logic [3:0]       bchain [M];
  stm_word_type     ldb_w  [M][4];
  logic [5:0]       cp     [M];
  logic [5:0]       opnd   [M];
  logic [3:0]       sm     [M];
  logic [3:0]       ext    [M];
  logic [3:0]       ovf    [M];
  logic             ovf_any;
  logic             halve;
  // output path
  stm_out_type      sipo_r;
  logic [4:0]       sipo_cnt_r;
  stm_out_type      hold_r;
  logic             hold_v_r;
  stm_out_type      e1_r;
  logic             v1_r;
  logic             push;
  logic             pop;
  logic             sipo_done;

  // all bit and word ticks stop while the buffer cannot take the held word
  always_comb
  begin
    tick      = (div_r == DW'(BIT_DIV - 1)) & ~(hold_v_r & v1_r);
    data_tick = tick & (bit_r != 4'(`STM_WORD_BITS - 1));
    gap_tick  = tick & (bit_r == 4'(`STM_WORD_BITS - 1));
    first     = (bit_r == 4'h0);
    last      = (bit_r == 4'(W - 1));
    push      = hold_v_r & ~v1_r;
    pop       = out_valid & out_ready;
    sipo_done = data_tick & latch_r[`STM_SI_OB]
                & (sipo_cnt_r == 5'(`STM_OUT_W - 1));
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      div_r <= '0;
    else if (div_r == DW'(BIT_DIV - 1))
      div_r <= '0;
    else
      div_r <= div_r + DW'(1);
  end

  // (RL25) thirteen bit times per word
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      bit_r <= 4'h0;
    else if (gap_tick)
      bit_r <= 4'h0;
    else if (data_tick)
      bit_r <= bit_r + 4'h1;
  end

  // (RL22) serial entry, latch at word end
  // (RL16) shift strobe comes from control
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      inst_sr_r <= '0;
      latch_r   <= '0;
    end
    else
    begin
      if (inst_shift)
        inst_sr_r <= {inst_bit, inst_sr_r[`STM_INST_W-1:1]};
      // (RL23) one bit enables one subinstruction
      if (gap_tick)
        latch_r <= inst_sr_r;
    end
  end

  for (genvar m = 0; m < M; m++)
  begin : g_mod
    localparam int PM = m / 2;
    localparam int PS = (m % 2) * 2;
    localparam int QM = (m + M) / 2;
    localparam int QS = ((m + M) % 2) * 2;
    localparam int K0 = stm_rev(2 * m);
    localparam int K1 = stm_rev(2 * m + 1);
    localparam int AA [4] = '{0, 1, 0, 1};
    localparam int AB [4] = '{5, 3, 2, 4};

    // (RL3) word-serial load chain, P then Q
    if (m == 0)
    begin : g_head
      // (RL2) real and imaginary lines in parallel
      assign dchain[m] = {d_r[M-1][1][0], d_r[M-1][0][0],
                          din_im, din_re};
    end
    else
    begin : g_body
      assign dchain[m] = {d_r[m-1][3][0], d_r[m-1][2][0],
                          d_r[m-1][1][0], d_r[m-1][0][0]};
    end

    // (RL9) next column pairs i with i+N/2
    assign shuf[m] = {a_r[QM][QS+1][0], a_r[QM][QS][0],
                      a_r[PM][PS+1][0], a_r[PM][PS][0]};

    // (RL8) unshuffle on load, chain flows upward
    assign ldb_w[m][0] = a_r[K0/2][(K0%2)*2];
    assign ldb_w[m][1] = a_r[K0/2][(K0%2)*2+1];
    assign ldb_w[m][2] = a_r[K1/2][(K1%2)*2];
    assign ldb_w[m][3] = a_r[K1/2][(K1%2)*2+1];
    if (m == M - 1)
    begin : g_btop
      assign bchain[m] = {1'b0, b_r[m][3][0], b_r[m][2][0],
                          b_r[m][1][0]};
    end
    else
    begin : g_bmid
      assign bchain[m] = {b_r[m+1][0][0], b_r[m][3][0],
                          b_r[m][2][0], b_r[m][1][0]};
    end

    // (RL21) reference/premultiply words replace data
    // when the STM_SI_USE_REF or STM_SI_USE_T latch bit is set
    always_comb
    begin
      opnd[m][0] = latch_r[`STM_SI_USE_REF] ?
                   reference_register_r[m][0][0] : d_r[m][0][0];
      opnd[m][1] = latch_r[`STM_SI_USE_REF] ?
                   reference_register_r[m][1][0] : d_r[m][1][0];
      opnd[m][2] = latch_r[`STM_SI_USE_T] ? t_r[m][0][0] : d_r[m][2][0];
      opnd[m][3] = latch_r[`STM_SI_USE_T] ? t_r[m][1][0] : d_r[m][3][0];
      opnd[m][4] = opnd[m][3];
      opnd[m][5] = opnd[m][2];
    end

    // (RL27) complementer_enable per complementer
    for (genvar c = 0; c < 6; c++)
    begin : g_cmp
      stm_complementer u_cmp (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .tick    (data_tick),
        .first   (first),
        .en      (latch_r[CB + c]),
        .din     (opnd[m][c]),
        .dout    (cp[m][c])
      );
    end

    // (RL11) sum and difference, real and imaginary
    // (RL18) four adders with overflow capture
    for (genvar j = 0; j < 4; j++)
    begin : g_add
      stm_serial_adder u_add (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .tick    (data_tick),
        .first   (first),
        .last    (last),
        .a       (cp[m][AA[j]]),
        .b       (cp[m][AB[j]]),
        .sum     (sm[m][j]),
        .ext_r   (ext[m][j]),
        .ovf_r   (ovf[m][j])
      );
    end
  end

  always_comb
  begin
    ovf_any = 1'b0;
    for (int m = 0; m < M; m++)
      ovf_any = ovf_any | (|ovf[m]);
    // (RL24) any overflow or notice halves all
    halve = latch_r[`STM_SI_ADD] & (ovf_any | ovf_notify);
  end

  // (RL17) eighteen words per module, shifted in place
  // (RL26) low bit leaves first
  // (RL20) data load may overlap the last add word
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      for (int m = 0; m < M; m++)
        for (int j = 0; j < 4; j++)
          d_r[m][j] <= '0;
    end
    else if (data_tick)
    begin
      for (int m = 0; m < M; m++)
        for (int j = 0; j < 4; j++)
          if (latch_r[`STM_SI_LDD])
            d_r[m][j] <= {dchain[m][j], d_r[m][j][W-1:1]};
          else if (latch_r[`STM_SI_LDA])
            d_r[m][j] <= {shuf[m][j], d_r[m][j][W-1:1]};
          else
            d_r[m][j] <= {d_r[m][j][0], d_r[m][j][W-1:1]};
    end
    else if (gap_tick && latch_r[`STM_SI_SHR])
    begin
      for (int m = 0; m < M; m++)
        for (int j = 0; j < 4; j++)
          d_r[m][j] <= {d_r[m][j][W-1], d_r[m][j][W-1:1]};
    end
  end

  // (RL10) every module steps on the same tick
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      for (int m = 0; m < M; m++)
        for (int j = 0; j < 4; j++)
          a_r[m][j] <= '0;
    end
    else if (data_tick)
    begin
      for (int m = 0; m < M; m++)
        for (int j = 0; j < 4; j++)
          a_r[m][j] <= {latch_r[`STM_SI_ADD] ? sm[m][j] : a_r[m][j][0],
                        a_r[m][j][W-1:1]};
    end
    // (RL19) halve with the true sign bit
    else if (gap_tick && halve)
    begin
      for (int m = 0; m < M; m++)
        for (int j = 0; j < 4; j++)
          a_r[m][j] <= {ext[m][j], a_r[m][j][W-1:1]};
    end
  end

  // (RL6) real leaves, imaginary steps into real
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      for (int m = 0; m < M; m++)
        for (int j = 0; j < 4; j++)
          b_r[m][j] <= '0;
    end
    else if (data_tick && latch_r[`STM_SI_OB])
    begin
      for (int m = 0; m < M; m++)
        for (int j = 0; j < 4; j++)
          b_r[m][j] <= {bchain[m][j], b_r[m][j][W-1:1]};
    end
    else if (gap_tick && latch_r[`STM_SI_LDB])
    begin
      for (int m = 0; m < M; m++)
        for (int j = 0; j < 4; j++)
          b_r[m][j] <= ldb_w[m][j];
    end
  end

  // (RL13) module m: real in m, imaginary in m+M
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      for (int k = 0; k < 2 * M; k++)
        coef_r[k] <= '0;
    end
    else if (data_tick)
    begin
      for (int k = 0; k < 2 * M; k++)
        if (!coef_load)
          coef_r[k] <= {coef_r[k][0], coef_r[k][W-1:1]};
        else if (k == 0)
          coef_r[k] <= {coef_in, coef_r[k][W-1:1]};
        else
          coef_r[k] <= {coef_r[k-1][0], coef_r[k][W-1:1]};
    end
  end

  // (RL14) premultiply pair and reference from coefficients
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      for (int m = 0; m < M; m++)
      begin
        for (int j = 0; j < 4; j++)
          t_r[m][j] <= '0;
        reference_register_r[m][0] <= '0;
        reference_register_r[m][1] <= '0;
      end
    end
    else if (data_tick)
    begin
      for (int m = 0; m < M; m++)
      begin
        if (latch_r[`STM_SI_LDT])
        begin
          t_r[m][0] <= {coef_r[m][0], t_r[m][0][W-1:1]};
          t_r[m][1] <= {coef_r[m+M][0], t_r[m][1][W-1:1]};
          t_r[m][2] <= {t_r[m][0][0], t_r[m][2][W-1:1]};
          t_r[m][3] <= {t_r[m][1][0], t_r[m][3][W-1:1]};
        end
        if (latch_r[`STM_SI_LDR])
        begin
          reference_register_r[m][0] <=
            {coef_r[m][0], reference_register_r[m][0][W-1:1]};
          reference_register_r[m][1] <=
            {coef_r[m+M][0], reference_register_r[m][1][W-1:1]};
        end
      end
    end
  end

  // (RL4) window grows by one per load word
  // (RL12) k add words make one transform
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      window_count  <= '0;
      iter_count    <= '0;
      result_ready  <= 1'b0;
      overflow_flag <= 1'b0;
      word_end      <= 1'b0;
    end
    else
    begin
      word_end     <= gap_tick;
      result_ready <= 1'b0;
      if (gap_tick)
      begin
        overflow_flag <= latch_r[`STM_SI_ADD] & ovf_any;
        if (latch_r[`STM_SI_CLRW])
          window_count <= '0;
        else if (latch_r[`STM_SI_LDD] && window_count != (LOG2N+1)'(2*M))
          window_count <= window_count + (LOG2N+1)'(1);
        if (latch_r[`STM_SI_CLRW])
          iter_count <= '0;
        else if (latch_r[`STM_SI_ADD])
        begin
          if (iter_count == LOG2N'(LOG2N - 1))
          begin
            iter_count   <= '0;
            result_ready <= 1'b1;
          end
          else
            iter_count <= iter_count + LOG2N'(1);
        end
      end
    end
  end

  // (RL5) all results out at once, bit serial
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      res_re_bits <= '0;
      res_im_bits <= '0;
    end
    else if (data_tick)
    begin
      for (int m = 0; m < M; m++)
      begin
        res_re_bits[2*m]   <= a_r[m][0][0];
        res_im_bits[2*m]   <= a_r[m][1][0];
        res_re_bits[2*m+1] <= a_r[m][2][0];
        res_im_bits[2*m+1] <= a_r[m][3][0];
      end
    end
  end

  // (RL7) 24-bit shifter then holding register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sipo_r     <= '0;
      sipo_cnt_r <= '0;
      hold_r     <= '0;
      hold_v_r   <= 1'b0;
    end
    else
    begin
      if (data_tick && latch_r[`STM_SI_OB])
      begin
        sipo_r     <= {b_r[0][0][0], sipo_r[`STM_OUT_W-1:1]};
        sipo_cnt_r <= sipo_done ? 5'h00 : sipo_cnt_r + 5'h01;
      end
      if (sipo_done)
        hold_r <= {b_r[0][0][0], sipo_r[`STM_OUT_W-1:1]};
      hold_v_r <= sipo_done | (hold_v_r & ~push);
    end
  end

  // two-entry buffer; a stall here stops the tick above
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      out_data  <= '0;
      out_valid <= 1'b0;
      e1_r      <= '0;
      v1_r      <= 1'b0;
      stall     <= 1'b0;
    end
    else
    begin
      stall <= hold_v_r & v1_r;
      if (pop && v1_r)
      begin
        out_data <= e1_r;
        e1_r     <= hold_r;
        v1_r     <= push;
      end
      else if (pop)
      begin
        out_data  <= hold_r;
        out_valid <= push;
      end
      else if (push && !out_valid)
      begin
        out_data  <= hold_r;
        out_valid <= 1'b1;
      end
      else if (push)
      begin
        e1_r <= hold_r;
        v1_r <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// [tb/stm_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none

module stm_ctrl_model
  import stm_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic word_end,
  input  wire logic sink_on,
  output logic      inst_bit,
  output logic      inst_shift,
  output logic      din_re,
  output logic      din_im,
  output logic      out_ready
);
  // real and imaginary together
  // all-ones samples make the result independent of tick phase
  assign din_re    = 1'b1;
  assign din_im    = 1'b1;
  assign out_ready = sink_on;

  initial
  begin
    inst_bit   = 1'b0;
    inst_shift = 1'b0;
  end

  // broadcast one word
  // shifting starts right after a boundary so all bits land before the gap
  task automatic send(input stm_inst_type inst, output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    while (n < 400 && !ok)
    begin
      @(negedge clk_sys);
      ok = word_end;
      n++;
    end
    if (!ok)
      return;
    for (int i = 0; i < $bits(inst); i++)
    begin
      @(posedge clk_sys);
      #1;
      inst_shift = 1'b1;
      inst_bit   = inst[i];
    end
    @(posedge clk_sys);
    #1;
    inst_shift = 1'b0;
  endtask
endmodule

`default_nettype wire

// [tb/stm_array_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module stm_array_chk
  import stm_pkg::*;
#(
  parameter int NUM_MOD = 4,
  parameter int BIT_DIV = 8
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  out_ready,
  input  wire stm_out_type           out_data,
  input  wire logic                  out_valid,
  input  wire logic                  word_end,
  input  wire logic                  overflow_flag,
  input  wire logic                  result_ready,
  input  wire logic                  stall,
  input  wire logic [$clog2(2*NUM_MOD):0]   window_count,
  input  wire logic [$clog2(2*NUM_MOD)-1:0] iter_count
);
  localparam int WLEN = 13 * BIT_DIV;
  int   gap_cnt_r;
  logic seen_r;
  logic stl_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      gap_cnt_r <= 0;
    else if (word_end)
      gap_cnt_r <= 1;
    else
      gap_cnt_r <= gap_cnt_r + 1;
  end

  // first word after reset has no previous boundary to measure from
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      seen_r <= 1'b0;
    else if (word_end)
      seen_r <= 1'b1;
  end

  // stall lags the suppressed tick by one cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      stl_r <= 1'b0;
    else if (word_end)
      stl_r <= stall;
    else
      stl_r <= stl_r | stall;
  end

  a_word_min: assert property (
    word_end && seen_r |-> gap_cnt_r >= WLEN)
    else $error("word boundary came early");
  a_word_max: assert property (
    gap_cnt_r == WLEN && !word_end && seen_r |-> stall || stl_r)
    else $error("word boundary late without stall");
  a_end_pulse: assert property (word_end |=> !word_end)
    else $error("word boundary pulse too long");
  a_rdy_pulse: assert property (result_ready |=> !result_ready [*8])
    else $error("result pulse repeated");
  a_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output word dropped or changed");
  a_win_sat: assert property (window_count <= 2 * NUM_MOD)
    else $error("window count beyond module capacity");
  a_win_step: assert property (
    $changed(window_count) && window_count != 0
      |-> window_count == $past(window_count) + 1 && word_end)
    else $error("window count stepped wrongly");
  a_flag_gap: assert property ($changed(overflow_flag) |-> word_end)
    else $error("overflow flag moved inside a word");
  a_iter_gap: assert property ($changed(iter_count) |-> word_end)
    else $error("iteration count moved inside a word");

  c_result: cover property (result_ready);
  c_pop: cover property (out_valid && out_ready);
  c_stall: cover property (stall);
endmodule

bind stm_array stm_array_chk #(
  .NUM_MOD (NUM_MOD),
  .BIT_DIV (BIT_DIV)
) u_chk (
  .clk_sys       (clk_sys),
  .rst_b         (rst_b),
  .out_ready     (out_ready),
  .out_data      (out_data),
  .out_valid     (out_valid),
  .word_end      (word_end),
  .overflow_flag (overflow_flag),
  .result_ready  (result_ready),
  .stall         (stall),
  .window_count  (window_count),
  .iter_count    (iter_count)
);

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb
  import stm_pkg::*;
;
  localparam int NM = 4;
  localparam stm_inst_type I_LDD = 23'h000001;
  localparam stm_inst_type I_ADD = 23'h001404;
  localparam stm_inst_type I_LDB = 23'h000008;
  localparam stm_inst_type I_OB  = 23'h000010;
  localparam stm_inst_type I_CLR = 23'h010000;

  logic clk_sys, rst_b, inst_bit, inst_shift, din_re, din_im;
  logic coef_in, coef_load, ovf_notify, out_ready, out_valid;
  logic word_end, overflow_flag, result_ready, stall, sink_on;
  stm_out_type                out_data;
  logic [2*NM-1:0]            res_re_bits, res_im_bits;
  logic [$clog2(2*NM):0]      window_count;
  logic [$clog2(2*NM)-1:0]    iter_count;
  logic [7:0]                 ev;
  logic                       seen_one;
  int errors, comparisons, rr_cnt;

  // two clocks per bit time lets a full instruction fit in one word
  stm_array #(.NUM_MOD(NM), .BIT_DIV(2)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .inst_bit(inst_bit),
    .inst_shift(inst_shift), .din_re(din_re), .din_im(din_im),
    .coef_in(coef_in), .coef_load(coef_load), .ovf_notify(ovf_notify),
    .out_ready(out_ready), .out_data(out_data), .out_valid(out_valid),
    .res_re_bits(res_re_bits), .res_im_bits(res_im_bits),
    .word_end(word_end), .overflow_flag(overflow_flag),
    .result_ready(result_ready), .stall(stall),
    .window_count(window_count), .iter_count(iter_count)
  );

  stm_ctrl_model ctl (
    .clk_sys(clk_sys), .word_end(word_end), .sink_on(sink_on),
    .inst_bit(inst_bit), .inst_shift(inst_shift), .din_re(din_re),
    .din_im(din_im), .out_ready(out_ready)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic go(input stm_inst_type inst);
    logic ok;
    ctl.send(inst, ok);
    chk(ok, 1);
    if (!ok)
      final_report();
  endtask

  // equal operands everywhere: differences zero, sums alike
  always @(negedge clk_sys)
  begin
    if (rst_b === 1'b1)
    begin
      ev = {res_im_bits[6], res_im_bits[4], res_im_bits[2], res_im_bits[0],
            res_re_bits[6], res_re_bits[4], res_re_bits[2], res_re_bits[0]};
      chk((res_re_bits | res_im_bits) & 8'hAA, 0);
      chk(ev == 8'h00 || ev == 8'hFF, 1);
      seen_one = seen_one | ev[0];
      rr_cnt = rr_cnt + int'(result_ready);
    end
  end

  task automatic t_reset();
    chk(window_count, 0);
    chk({out_valid, stall, overflow_flag}, 0);
  endtask

  task automatic t_window();
    go(I_CLR);
    repeat (3) go(I_LDD);
    repeat (2) go('0);
    chk(window_count, 3);
    repeat (6) go(I_LDD);
    repeat (2) go('0);
    chk(window_count, 2 * NM);
  endtask

  task automatic t_add();
    // notice halves every module: -2 becomes -1
    ovf_notify = 1'b1;
    go(I_ADD);
    go(I_ADD);
    go(I_ADD);
    chk(iter_count, 1);
    go('0);
    chk({iter_count, 8'(rr_cnt)}, {3'd2, 8'd0});
    go('0);
    chk(rr_cnt, 1);
    chk(overflow_flag, 0);
    chk(seen_one, 1);
    ovf_notify = 1'b0;
  endtask

  task automatic t_out();
    stm_out_type exp [3];
    int n;
    int k;
    // x0, x1, x2 are halved sums; x1 comes from module 2 after reversal
    exp = '{24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF};
    n = 0;
    k = 0;
    go(I_LDB);
    repeat (6) go(I_OB);
    go('0);
    repeat (40) @(posedge clk_sys);
    chk({stall, out_valid}, 2'b11);
    #1;
    sink_on = 1'b1;
    while (k < 3 && n < 60)
    begin
      @(negedge clk_sys);
      if (out_valid === 1'b1)
      begin
        chk(out_data, exp[k]);
        k++;
      end
      n++;
    end
    chk(k, 3);
  endtask

  initial
  begin
    rst_b      = 1'b0;
    coef_in    = 1'b0;
    coef_load  = 1'b0;
    ovf_notify = 1'b0;
    sink_on    = 1'b0;
    seen_one   = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_window();
    t_add();
    t_out();
    final_report();
  end
endmodule

`default_nettype wire
